// ===== hdl/hpss_pkg.sv
// Package of constants and carrier types for the hot-plug slot status flags.
package hpss_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    // Configuration offset of the slot status word.
    localparam logic [7:0] HPSS_SLOT_STATUS_OFS = 8'hba;
    localparam int HPSS_WORD_W = 16;
    localparam logic [15:0] HPSS_SLOT_STATUS_RESET = 16'h0000;

    // ==========================================================
    // Field positions in the slot status word
    // ==========================================================
    localparam int HPSS_RSVD_MSB = 15;
    localparam int HPSS_RSVD_LSB = 7;
    localparam int HPSS_BIT_PRESENCE_NOW = 6;
    localparam int HPSS_BIT_RSVD_MID = 5;
    localparam int HPSS_BIT_CMD_DONE = 4;
    localparam int HPSS_BIT_PRESENCE_CHANGED = 3;
    localparam int HPSS_BIT_LATCH_CHANGED = 2;
    localparam int HPSS_BIT_POWER_FAULT = 1;
    localparam int HPSS_BIT_BUTTON_PRESSED = 0;
    // Byte lane that carries the write-one-to-clear flag.
    localparam int HPSS_CLEAR_LANE = 0;

    // ==========================================================
    // Synchroniser timing
    // ==========================================================
    localparam int HPSS_SYNC_STAGES = 2;
    // Edges after reset before the synchronised pins may be trusted.
    localparam logic [1:0] HPSS_WARMUP_DONE = 2'(HPSS_SYNC_STAGES);

    // ==========================================================
    // Carrier types
    // ==========================================================
    // One configuration access from the port's config logic.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [1:0] byteEn;
        logic [15:0] wrData;
    } hpss_cfg_req_t;

    // Levels that arrive on pins from the slot and from the straps.
    typedef struct packed {
        logic buttonSupported;
        logic faultSupported;
        logic latchSupported;
        logic cmdDoneSupported;
        logic slotImplemented;
        logic buttonPin;
        logic latchSensor;
        logic oobPresence;
    } hpss_pins_t;

    // Whole state of the status flag block.
    typedef struct packed {
        logic [1:0] warmup;
        logic primed;
        logic presence;
        logic latchPrev;
        logic buttonPrev;
        logic cmdDone;
        logic presChg;
        logic latchChg;
        logic pwrFault;
        logic button;
        logic rdValid;
        logic [15:0] rdData;
    } hpss_state_t;

endpackage

// ===== hdl/hpss_sync.sv
// Two-stage synchroniser for a vector of pin levels.
`timescale 1ns/10ps
module hpss_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Levels from outside the clock domain
    input wire logic [WIDTH-1:0] asyncIn,
    // Levels safe for core logic
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } hpss_sync_state_t;

    hpss_sync_state_t st;
    hpss_sync_state_t next_st;

    // ==========================================================
    // Shift chain
    // ==========================================================
    // The first stage is read only by the second stage.
    always_comb begin
        next_st.stage1 = asyncIn;
        next_st.stage2 = st.stage1;
    end

    // Both stages clear to zero under reset.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.stage2;

endmodule // hpss_sync

// ===== hdl/hpss_status.sv
// Slot status word of a hot-plug root port: presence and sticky event flags.
`timescale 1ns/10ps
module hpss_status (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration access
    input wire hpss_pkg::hpss_cfg_req_t cfgReq,
    output logic [15:0] cfgRdData,
    output logic cfgRdValid,
    // Slot pins and capability straps, asynchronous
    input wire hpss_pkg::hpss_pins_t slotPins,
    // Events from logic on the core clock
    input wire logic inbandPresence,
    input wire logic cmdDoneEvent,
    input wire logic powerFaultEvent,
    // Current slot occupancy
    output logic presenceNow
);

    // ==========================================================
    // Declarations
    // ==========================================================
    hpss_pkg::hpss_state_t st;
    hpss_pkg::hpss_state_t next_st;
    logic [$bits(hpss_pkg::hpss_pins_t)-1:0] syncBus;
    hpss_pkg::hpss_pins_t pinS;
    logic presSrc;
    logic presEvt;
    logic latchEvt;
    logic buttonEvt;
    logic wrHit;
    logic rdHit;
    logic clearHit;

    // True when an access addresses the slot status word.
    function automatic logic addr_hit(input logic [7:0] addr);
        addr_hit = (addr == hpss_pkg::HPSS_SLOT_STATUS_OFS);
    endfunction

    // Assemble the word that software sees; reserved bits stay zero.
    function automatic logic [15:0] pack_status(
        input hpss_pkg::hpss_state_t s,
        input logic cmdSup
    );
        logic [15:0] w;
        w = hpss_pkg::HPSS_SLOT_STATUS_RESET;
        w[hpss_pkg::HPSS_BIT_PRESENCE_NOW] = s.presence;
        w[hpss_pkg::HPSS_BIT_CMD_DONE] = s.cmdDone & cmdSup;
        w[hpss_pkg::HPSS_BIT_PRESENCE_CHANGED] = s.presChg;
        w[hpss_pkg::HPSS_BIT_LATCH_CHANGED] = s.latchChg;
        w[hpss_pkg::HPSS_BIT_POWER_FAULT] = s.pwrFault;
        w[hpss_pkg::HPSS_BIT_BUTTON_PRESSED] = s.button;
        pack_status = w;
    endfunction

    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    // Slot pins and straps all come from outside this clock domain.
    hpss_sync #(
        .WIDTH($bits(hpss_pkg::hpss_pins_t))
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(slotPins),
        .syncOut(syncBus)
    );

    assign pinS = hpss_pkg::hpss_pins_t'(syncBus);

    // ==========================================================
    // Event detection
    // ==========================================================
    // No presence, latch or button change is flagged until the synchroniser has filled after reset:
    // its zeros would look like a port without a slot, which reads as occupied, and fake
    // a presence change once the real pin levels arrive.
    always_comb begin
        presSrc = 1'b1;
        if (pinS.slotImplemented) begin
            presSrc = inbandPresence | pinS.oobPresence;
        end
        presEvt = st.primed && (presSrc != st.presence);
        latchEvt = st.primed && pinS.latchSupported &&
            (pinS.latchSensor != st.latchPrev);
        buttonEvt = st.primed && pinS.buttonSupported &&
            pinS.buttonPin && !st.buttonPrev;
        wrHit = cfgReq.wr && addr_hit(cfgReq.addr);
        rdHit = cfgReq.rd && addr_hit(cfgReq.addr);
        // Only a one in the flag's own lane clears it; zeros are ignored.
        clearHit = wrHit && cfgReq.byteEn[hpss_pkg::HPSS_CLEAR_LANE] &&
            cfgReq.wrData[hpss_pkg::HPSS_BIT_PRESENCE_CHANGED];
    end

    // ==========================================================
    // Next state
    // ==========================================================
    // A new event in the cycle of a clear wins, so it is never lost.
    always_comb begin
        next_st = st;
        // Presence waits until the synchronised pins are real; the latch and button history follows the pins every cycle.
        if (st.warmup != hpss_pkg::HPSS_WARMUP_DONE) begin
            next_st.warmup = st.warmup + 2'h1;
        end
        next_st.primed = (st.warmup == hpss_pkg::HPSS_WARMUP_DONE);
        if (next_st.primed) begin
            next_st.presence = presSrc;
        end
        next_st.latchPrev = pinS.latchSensor;
        next_st.buttonPrev = pinS.buttonPin;
        // Sticky flags; a dropped capability forces its flag low.
        next_st.cmdDone = pinS.cmdDoneSupported &&
            (st.cmdDone || cmdDoneEvent);
        next_st.presChg = presEvt || (st.presChg && !clearHit);
        next_st.latchChg = pinS.latchSupported &&
            (st.latchChg || latchEvt);
        // Fault reporting is not gated by power state or occupancy.
        next_st.pwrFault = pinS.faultSupported &&
            (st.pwrFault || powerFaultEvent);
        next_st.button = pinS.buttonSupported &&
            (st.button || buttonEvt);
        // Read answer one cycle after the request; unmapped reads zero.
        next_st.rdValid = cfgReq.rd;
        next_st.rdData = '0;
        if (rdHit) begin
            next_st.rdData = pack_status(st, pinS.cmdDoneSupported);
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // All outputs are flip-flop bits of the state.
    assign cfgRdData = st.rdData;
    assign cfgRdValid = st.rdValid;
    assign presenceNow = st.presence;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Reserved bits above presence and between presence and command-done.
    a_reserved_zero: assert property (
        cfgRdValid |-> (cfgRdData[15:7] == 9'h000 && !cfgRdData[5])
    ) else $error("reserved status bit read as one");

    // Presence follows the OR of both indications one cycle later.
    a_presence_or: assert property (
        (st.primed && $past(pinS.slotImplemented)) |->
            presenceNow == ($past(inbandPresence) | $past(pinS.oobPresence))
    ) else $error("presence is not the OR of its sources");

    // A port without a slot always reports an occupied slot.
    a_no_slot_one: assert property (
        (st.primed && !$past(pinS.slotImplemented)) |-> presenceNow
    ) else $error("presence not one on a port without a slot");

    // Read data carries the presence that was held at the request.
    a_presence_read: assert property (
        rdHit |=> cfgRdData[6] == $past(st.presence)
    ) else $error("read presence does not match slot occupancy");

    // A completed command shows up on the next edge.
    a_cmd_done_set: assert property (
        (cmdDoneEvent && pinS.cmdDoneSupported) |=> st.cmdDone
    ) else $error("command done not set after completion");

    // Without notification support the flag stays low.
    a_cmd_done_tied: assert property (
        !pinS.cmdDoneSupported |=> (!st.cmdDone ##1 !cfgRdData[4])
    ) else $error("command done set without support");

    // A presence change raises the changed flag in the same update.
    a_pres_chg_set: assert property (
        ($past(st.primed) && $changed(st.presence)) |-> st.presChg
    ) else $error("presence change not flagged");

    // The flag holds until a one is written to it.
    a_pres_chg_hold: assert property (
        (st.presChg && !clearHit) |=> st.presChg
    ) else $error("presence changed flag dropped without a clear");

    // A clear with no new change empties the flag next cycle.
    a_pres_chg_clear: assert property (
        (clearHit && !presEvt) |=> !st.presChg
    ) else $error("presence changed flag survived its clear");

    // A detected latch sensor change is flagged.
    a_latch_set: assert property (
        latchEvt |=> st.latchChg
    ) else $error("latch sensor change not flagged");

    // No sensor fitted, no flag.
    a_latch_never: assert property (
        !pinS.latchSupported |=> !st.latchChg
    ) else $error("latch flag set without a sensor");

    // A reported fault is flagged whatever the slot occupancy.
    a_fault_set: assert property (
        (powerFaultEvent && pinS.faultSupported) |=> st.pwrFault
    ) else $error("power fault not flagged");

    // Without detection the fault flag never rises.
    a_fault_never: assert property (
        !pinS.faultSupported |=> !st.pwrFault
    ) else $error("power fault flag set without detection");

    // A rising button level is flagged on the next edge.
    a_button_set: assert property (
        buttonEvt |=> st.button
    ) else $error("button press not flagged");

    // Without a button the flag never rises.
    a_button_never: assert property (
        !pinS.buttonSupported |=> !st.button
    ) else $error("button flag set without a button");

    // Writes of all ones leave the read-only flags where they were.
    a_ro_write: assert property (
        (wrHit && st.pwrFault && st.button && st.latchChg &&
            pinS.faultSupported && pinS.buttonSupported &&
            pinS.latchSupported) |=> (st.pwrFault && st.button && st.latchChg)
    ) else $error("write disturbed a read-only flag");

    // No presence, latch or button flag may rise while the synchroniser is still filling.
    a_warmup_quiet: assert property (
        !st.primed |=> !(st.presChg || st.latchChg || st.button)
    ) else $error("flag raised during the warm-up after reset");

    // Presence keeps its reset value until the pins are trusted.
    a_warmup_presence: assert property (
        (st.warmup != hpss_pkg::HPSS_WARMUP_DONE) |=> $stable(presenceNow)
    ) else $error("presence moved during the warm-up after reset");

    // Every read request is answered on the next edge.
    a_rd_answer: assert property (
        cfgReq.rd |=> cfgRdValid
    ) else $error("read request not answered");

    // The answer stands for one cycle only.
    a_rd_single: assert property (
        !cfgReq.rd |=> !cfgRdValid
    ) else $error("read answer without a request");

    // Reads of other offsets return an all-zero word.
    a_unmapped_zero: assert property (
        (cfgReq.rd && !rdHit) |=> (cfgRdData == 16'h0000)
    ) else $error("read of another offset returned ones");

    // Without notification support the read shows command-done low.
    a_cmd_read_mask: assert property (
        (rdHit && !pinS.cmdDoneSupported) |=> !cfgRdData[4]
    ) else $error("command done read as one without support");

    // A change in the cycle of a clear leaves the flag set.
    a_pres_chg_wins: assert property (
        (presEvt && clearHit) |=> st.presChg
    ) else $error("presence change lost against a clear");

    // Command-done is sticky while its support stays.
    a_cmd_done_hold: assert property (
        (st.cmdDone && pinS.cmdDoneSupported) |=> st.cmdDone
    ) else $error("command done dropped on its own");

    // The latch flag is sticky while the sensor stays fitted.
    a_latch_hold: assert property (
        (st.latchChg && pinS.latchSupported) |=> st.latchChg
    ) else $error("latch flag dropped on its own");

    // The fault flag is sticky while detection stays supported.
    a_fault_hold: assert property (
        (st.pwrFault && pinS.faultSupported) |=> st.pwrFault
    ) else $error("power fault flag dropped on its own");

    // The button flag is sticky while the button stays fitted.
    a_button_hold: assert property (
        (st.button && pinS.buttonSupported) |=> st.button
    ) else $error("button flag dropped on its own");

endmodule // hpss_status

// ===== verif/hpss_slot_model.sv
// Behavioural model of the slot sensors, adapter card and power controller.
`timescale 1ns/10ps
module hpss_slot_model (
    // Clock
    input wire logic core_clk,
    // Pins, straps and controller events towards the status block
    output hpss_pkg::hpss_pins_t slotPins,
    output logic inbandPresence,
    output logic cmdDoneEvent,
    output logic powerFaultEvent
);
    // Idle slot at time zero: fitted, empty, no options.
    initial begin
        slotPins = '0;
        slotPins.slotImplemented = 1'b1;
        inbandPresence = 1'b0;
        cmdDoneEvent = 1'b0;
        powerFaultEvent = 1'b0;
    end

    // Pins move just after the falling edge, well away from sampling.
    task automatic set_pins(input hpss_pkg::hpss_pins_t v);
        @(negedge core_clk);
        slotPins = v;
    endtask

    // The link layer reports a trained card as a plain level.
    task automatic set_inband(input logic v);
        @(negedge core_clk);
        inbandPresence = v;
    endtask

    // The controller signals a processed command for one cycle only.
    task automatic pulse_cmd();
        @(negedge core_clk);
        cmdDoneEvent = 1'b1;
        @(negedge core_clk);
        cmdDoneEvent = 1'b0;
    endtask

    // A power fault may be reported whatever the slot state is.
    task automatic pulse_fault();
        @(negedge core_clk);
        powerFaultEvent = 1'b1;
        @(negedge core_clk);
        powerFaultEvent = 1'b0;
    endtask
endmodule // hpss_slot_model

// ===== verif/test_hpss_status.sv
// Self-checking testbench of the hot-plug slot status flags.
`timescale 1ns/10ps
module test_hpss_status;
    // ==========================================================
    // Signals and instances
    // ==========================================================
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    hpss_pkg::hpss_cfg_req_t cfgReq = '0;
    hpss_pkg::hpss_pins_t slotPins;
    hpss_pkg::hpss_pins_t pinsTb;
    logic [15:0] cfgRdData;
    logic cfgRdValid;
    logic inbandPresence;
    logic cmdDoneEvent;
    logic powerFaultEvent;
    logic presenceNow;
    logic [15:0] rdWord;
    int n_fail = 0;
    int checked = 0;

    // A 50 MHz core clock.
    always #10 core_clk = ~core_clk;

    hpss_slot_model i_slot (
        .core_clk(core_clk),
        .slotPins(slotPins),
        .inbandPresence(inbandPresence),
        .cmdDoneEvent(cmdDoneEvent),
        .powerFaultEvent(powerFaultEvent)
    );

    hpss_status i_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cfgReq(cfgReq),
        .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid),
        .slotPins(slotPins),
        .inbandPresence(inbandPresence),
        .cmdDoneEvent(cmdDoneEvent),
        .powerFaultEvent(powerFaultEvent),
        .presenceNow(presenceNow)
    );

    // ==========================================================
    // Shared tasks
    // ==========================================================
    // Verdict and end of run, reached from the main sequence and from read_word when a read answer is missing.
    task automatic summarize();
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Pin levels need two synchroniser flops plus one state edge.
    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        rst_n = 1'b0;
        settle(5);
        rst_n = 1'b1;
        settle(5);
    endtask

    // One-cycle read; the answer is waited for under a small bound.
    task automatic read_word(input logic [7:0] addr);
        int i;
        @(negedge core_clk);
        cfgReq.addr = addr;
        cfgReq.rd = 1'b1;
        @(negedge core_clk);
        cfgReq.rd = 1'b0;
        for (i = 0; i < 3 && cfgRdValid !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        if (cfgRdValid !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t: read answer missing", $time);
            summarize();
        end
        rdWord = cfgRdData;
    endtask

    // Writes keep the reserved upper field at zero.
    task automatic write_word(input logic [15:0] data);
        @(negedge core_clk);
        cfgReq.addr = hpss_pkg::HPSS_SLOT_STATUS_OFS;
        cfgReq.byteEn = 2'h3;
        cfgReq.wrData = data & 16'h007f;
        cfgReq.wr = 1'b1;
        @(negedge core_clk);
        cfgReq.wr = 1'b0;
        settle(1);
    endtask

    task automatic expect_status(input logic [15:0] exp);
        read_word(hpss_pkg::HPSS_SLOT_STATUS_OFS);
        check(rdWord, exp);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_presence();
        expect_status(16'h0000);
        pinsTb.oobPresence = 1'b1;
        i_slot.set_pins(pinsTb);
        settle(5);
        expect_status(16'h0048);
        write_word(16'h0000);
        expect_status(16'h0048);
        write_word(16'h0008);
        expect_status(16'h0040);
        // Hand presence over to the in-band path without a gap.
        i_slot.set_inband(1'b1);
        pinsTb.oobPresence = 1'b0;
        i_slot.set_pins(pinsTb);
        settle(5);
        expect_status(16'h0040);
        i_slot.set_inband(1'b0);
        settle(5);
        check({15'h0000, presenceNow}, 16'h0000);
        expect_status(16'h0008);
        write_word(16'h0037);
        expect_status(16'h0008);
    endtask

    // Refused writes, a foreign offset, and a change that meets a clear.
    task automatic t_access();
        @(negedge core_clk);
        cfgReq.addr = hpss_pkg::HPSS_SLOT_STATUS_OFS;
        cfgReq.byteEn = 2'h2;
        cfgReq.wrData = 16'h0008;
        cfgReq.wr = 1'b1;
        @(negedge core_clk);
        cfgReq.addr = 8'hbc;
        cfgReq.byteEn = 2'h3;
        @(negedge core_clk);
        cfgReq.wr = 1'b0;
        expect_status(16'h0008);
        read_word(8'hbc);
        check(rdWord, 16'h0000);
        write_word(16'h0008);
        expect_status(16'h0000);
        // The set must win when it lands on the edge of the clear.
        fork
            i_slot.set_inband(1'b1);
            write_word(16'h0008);
        join
        expect_status(16'h0048);
        i_slot.set_inband(1'b0);
        settle(5);
        expect_status(16'h0008);
    endtask

    // Every event with its option absent must leave the word clear.
    task automatic t_events_off();
        do_reset();
        pinsTb.latchSensor = 1'b1;
        pinsTb.buttonPin = 1'b1;
        i_slot.set_pins(pinsTb);
        settle(4);
        pinsTb.latchSensor = 1'b0;
        pinsTb.buttonPin = 1'b0;
        i_slot.set_pins(pinsTb);
        i_slot.pulse_cmd();
        i_slot.pulse_fault();
        settle(5);
        expect_status(16'h0000);
    endtask

    // Same events with every option fitted and the slot empty.
    task automatic t_events_on();
        pinsTb.cmdDoneSupported = 1'b1;
        pinsTb.latchSupported = 1'b1;
        pinsTb.faultSupported = 1'b1;
        pinsTb.buttonSupported = 1'b1;
        i_slot.set_pins(pinsTb);
        settle(5);
        pinsTb.latchSensor = 1'b1;
        pinsTb.buttonPin = 1'b1;
        i_slot.set_pins(pinsTb);
        i_slot.pulse_cmd();
        i_slot.pulse_fault();
        settle(5);
        expect_status(16'h0017);
        write_word(16'h0077);
        expect_status(16'h0017);
        pinsTb.cmdDoneSupported = 1'b0;
        i_slot.set_pins(pinsTb);
        settle(5);
        expect_status(16'h0007);
    endtask

    // A port without a slot reports a card regardless of the pins.
    task automatic t_no_slot();
        do_reset();
        pinsTb = '0;
        i_slot.set_pins(pinsTb);
        settle(5);
        read_word(hpss_pkg::HPSS_SLOT_STATUS_OFS);
        check(rdWord & 16'hfff7, 16'h0040);
        check({15'h0000, presenceNow}, 16'h0001);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        pinsTb = '0;
        pinsTb.slotImplemented = 1'b1;
        settle(5);
        rst_n = 1'b1;
        settle(5);
        t_presence();
        t_access();
        t_events_off();
        t_events_on();
        t_no_slot();
        summarize();
    end
endmodule // test_hpss_status
